// ==== src/gpclk_consts.vh ====
`ifndef GPCLK_CONSTS_VH
`define GPCLK_CONSTS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GPCLK_OFS_OUT      4'h0
`define GPCLK_OFS_DIR      4'h1
`define GPCLK_OFS_IN       4'h2
`define GPCLK_OFS_IEN      4'h3
`define GPCLK_OFS_TYPE_LO  4'h4
`define GPCLK_OFS_TYPE_HI  4'h5
`define GPCLK_OFS_STAT     4'h6
`define GPCLK_OFS_CLKCTL   4'h7
`define GPCLK_OFS_DIV14    4'h8
`define GPCLK_OFS_DIV15    4'h9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPCLK_RST_DIR      16'hffff
`define GPCLK_RST_CLKCTL   2'h2
`define GPCLK_RST_DIV      8'h00
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define GPCLK_WARM_CYC     2'h3
// ----------------------------------------
// Detection types
// ----------------------------------------
`define GPCLK_DET_HIGH     3'h0
`define GPCLK_DET_LOW      3'h1
`define GPCLK_DET_RISE     3'h2
`define GPCLK_DET_FALL     3'h3
`define GPCLK_DET_BOTH     3'h4
// ----------------------------------------
// Clock output limit
// ----------------------------------------
`define GPCLK_CLK_MHZ      25
`define GPCLK_MAX_OUT_KHZ  33330
`endif

// ==== src/gpclk_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-stage input synchroniser
// ----------------------------------------
module gpclk_sync #(
   parameter W = 16
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_b,
   // Data
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
      end
      else
      begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end

   assign q = s2_reg;
endmodule // gpclk_sync
`default_nettype wire

// ==== src/gpclk_div.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Programmable clock divider
// ----------------------------------------
module gpclk_div #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_b,
   // Control
   input  wire         en,
   input  wire [W-1:0] half,
   // Output
   output wire         clk_out
);
   reg [W-1:0] cnt_reg;
   reg         tog_reg;

   // Half period is half+1 cycles, so output is at most clk/2 (12.5 MHz)
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_reg <= {W{1'b0}};
         tog_reg <= 1'b0;
      end
      else if (!en)
      begin
         cnt_reg <= {W{1'b0}};
         tog_reg <= 1'b0;
      end
      else if (cnt_reg >= half)
      begin
         cnt_reg <= {W{1'b0}};
         tog_reg <= ~tog_reg;
      end
      else
      begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign clk_out = tog_reg;
endmodule // gpclk_div
`default_nettype wire

// ==== src/gpclk_top.v ====
`include "gpclk_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module gpclk_top #(
   parameter NPIN = 16,
   parameter NIRQ = 13,
   parameter DW   = 8
) (
   // Clock and reset
   input  wire            clk,
   input  wire            rst_b,
   // Register port
   input  wire [3:0]      addr,
   input  wire [31:0]     wdata,
   input  wire            wr,
   input  wire            rd,
   output reg  [31:0]     rdata,
   // Pins
   input  wire [NPIN-1:0] pin_in,
   output reg  [NPIN-1:0] pin_out,
   output reg  [NPIN-1:0] pin_oe_b,
   // Event flags
   output wire [NIRQ-1:0] event_flags,
   output wire            event_any
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg  [NPIN-1:0]   out_reg;
   reg  [NPIN-1:0]   dir_reg;
   reg  [NIRQ-1:0]   ien_reg;
   reg  [3*NIRQ-1:0] type_reg;
   reg  [NIRQ-1:0]   stat_reg;
   wire [NIRQ-1:0]   stat_next;
   reg  [1:0]        clkctl_reg;
   reg  [DW-1:0]     div14_reg;
   reg  [DW-1:0]     div15_reg;
   reg  [NPIN-1:0]   prev_reg;
   wire [NPIN-1:0]   sync_in;
   wire              clk14;
   wire              clk15;
   reg  [1:0]        warm_reg;
   wire              warm;

   // ----------------------------------------
   // Detection function
   // ----------------------------------------
   function det;
      input [2:0] t;
      input       cur;
      input       prv;
      begin
         case (t)
            `GPCLK_DET_HIGH: det = cur;
            `GPCLK_DET_LOW:  det = ~cur;
            `GPCLK_DET_RISE: det = cur & ~prv;
            `GPCLK_DET_FALL: det = ~cur & prv;
            `GPCLK_DET_BOTH: det = cur ^ prv;
            default:         det = 1'b0;
         endcase
      end
   endfunction

   function is_edge;
      input [2:0] t;
      begin
         is_edge = (t == `GPCLK_DET_RISE) || (t == `GPCLK_DET_FALL)
                   || (t == `GPCLK_DET_BOTH);
      end
   endfunction

   // ----------------------------------------
   // Synchroniser and dividers
   // ----------------------------------------
   gpclk_sync #(.W(NPIN)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (pin_in),
      .q     (sync_in)
   );

   gpclk_div #(.W(DW)) u_div14 (
      .clk     (clk),
      .rst_b   (rst_b),
      .en      (clkctl_reg[0]),
      .half    (div14_reg),
      .clk_out (clk14)
   );

   gpclk_div #(.W(DW)) u_div15 (
      .clk     (clk),
      .rst_b   (rst_b),
      .en      (clkctl_reg[1]),
      .half    (div15_reg),
      .clk_out (clk15)
   );

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_reg    <= {NPIN{1'b0}};
         dir_reg    <= `GPCLK_RST_DIR;
         ien_reg    <= {NIRQ{1'b0}};
         type_reg   <= {(3*NIRQ){1'b0}};
         clkctl_reg <= `GPCLK_RST_CLKCTL;
         div14_reg  <= `GPCLK_RST_DIV;
         div15_reg  <= `GPCLK_RST_DIV;
      end
      else if (wr)
      begin
         case (addr)
            `GPCLK_OFS_OUT:     out_reg <= wdata[NPIN-1:0];
            `GPCLK_OFS_DIR:     dir_reg <= wdata[NPIN-1:0];
            `GPCLK_OFS_IEN:     ien_reg <= wdata[NIRQ-1:0];
            `GPCLK_OFS_TYPE_LO: type_reg[20:0] <= wdata[20:0];
            `GPCLK_OFS_TYPE_HI: type_reg[38:21] <= wdata[17:0];
            `GPCLK_OFS_CLKCTL:  clkctl_reg <= wdata[1:0];
            `GPCLK_OFS_DIV14:   div14_reg <= wdata[DW-1:0];
            `GPCLK_OFS_DIV15:   div15_reg <= wdata[DW-1:0];
            default:            out_reg <= out_reg;
         endcase
      end
   end

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NIRQ; g = g + 1)
      begin : g_det
         wire armed = ien_reg[g] & dir_reg[g] & warm;
         wire hit   = armed & det(type_reg[3*g+2:3*g], sync_in[g], prev_reg[g]);
         wire lvl   = ~is_edge(type_reg[3*g+2:3*g]);
         wire clr   = wr && (addr == `GPCLK_OFS_STAT) && wdata[g];
         // Level flags follow the pin; edge flags stick, set beats clear
         assign stat_next[g] = lvl ? hit : (hit | (~clr & stat_reg[g]));
      end
   endgenerate

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stat_reg <= {NIRQ{1'b0}};
         prev_reg <= {NPIN{1'b0}};
      end
      else
      begin
         stat_reg <= stat_next;
         prev_reg <= sync_in;
      end
   end

   assign event_flags = stat_reg;
   assign event_any   = |stat_reg;

   // Detection waits until synchroniser and previous sample hold real levels,
   // so a pin pulled high through reset raises no false edge
   assign warm = (warm_reg == `GPCLK_WARM_CYC);

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         warm_reg <= 2'h0;
      else if (!warm)
         warm_reg <= warm_reg + 2'h1;
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_out  <= {NPIN{1'b0}};
         pin_oe_b <= {1'b0, {(NPIN-1){1'b1}}};
      end
      else
      begin
         pin_out  <= {clkctl_reg[1] ? clk15 : out_reg[15],
                      clkctl_reg[0] ? clk14 : out_reg[14],
                      out_reg[13:0]};
         pin_oe_b <= {dir_reg[15] & ~clkctl_reg[1],
                      dir_reg[14] & ~clkctl_reg[0],
                      dir_reg[13:0]};
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= 32'h00000000;
      else if (rd)
      begin
         case (addr)
            `GPCLK_OFS_OUT:     rdata <= {16'h0000, out_reg};
            `GPCLK_OFS_DIR:     rdata <= {16'h0000, dir_reg};
            `GPCLK_OFS_IN:      rdata <= {16'h0000, sync_in};
            `GPCLK_OFS_IEN:     rdata <= {19'h00000, ien_reg};
            `GPCLK_OFS_TYPE_LO: rdata <= {11'h000, type_reg[20:0]};
            `GPCLK_OFS_TYPE_HI: rdata <= {14'h0000, type_reg[38:21]};
            `GPCLK_OFS_STAT:    rdata <= {19'h00000, stat_reg};
            `GPCLK_OFS_CLKCTL:  rdata <= {30'h00000000, clkctl_reg};
            `GPCLK_OFS_DIV14:   rdata <= {24'h000000, div14_reg};
            `GPCLK_OFS_DIV15:   rdata <= {24'h000000, div15_reg};
            default:            rdata <= 32'h00000000;
         endcase
      end
      else
         rdata <= 32'h00000000;
   end
endmodule // gpclk_top
`default_nettype wire

// ==== verification/gpclk_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module gpclk_props #(
   parameter NPIN = 16,
   parameter NIRQ = 13
) (
   // Clock and reset
   input wire logic            clk,
   input wire logic            rst_b,
   // Register port
   input wire logic [3:0]      addr,
   input wire logic [31:0]     wdata,
   input wire logic            wr,
   input wire logic            rd,
   input wire logic [31:0]     rdata,
   // Pins and flags
   input wire logic [NPIN-1:0] pin_in,
   input wire logic [NPIN-1:0] pin_out,
   input wire logic [NPIN-1:0] pin_oe_b,
   input wire logic [NIRQ-1:0] event_flags,
   input wire logic            event_any
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_dir_wr;
      (wr && addr == 4'h1) ##1 !(wr && addr == 4'h1);
   endsequence
   sequence s_tog;
      pin_out[15] != $past(pin_out[15]) && !pin_oe_b[15];
   endsequence
   sequence s_ctl14_wr;
      (wr && addr == 4'h7 && wdata[0]) ##1 !(wr && addr == 4'h7);
   endsequence
   property p_clk14;
      s_ctl14_wr |=> !pin_oe_b[14];
   endproperty
   property p_dir;
      s_dir_wr |=> pin_oe_b[13:0] == $past(wdata[13:0], 2);
   endproperty
   property p_rdz;
      !$past(rd) |-> rdata == 32'h0;
   endproperty
   // Input path is two flops deep, so a read shows the level from three edges back
   property p_in;
      rd && addr == 4'h2 && $past(rst_b) && $past(rst_b, 2) |=> rdata[15:0] == $past(pin_in, 3);
   endproperty
   property p_rst;
      $rose(rst_b) |-> pin_oe_b == 16'h7fff && pin_out[14:0] == 15'h0;
   endproperty
   property p_clk15;
      // Divider flips on the first edge out of reset, the pin follows one edge later
      $rose(rst_b) |-> ##2 s_tog [*3];
   endproperty
   property p_any;
      event_any == (|event_flags);
   endproperty
   a_dir: assert property (p_dir) else $error("pin direction differs from written value");
   a_rdz: assert property (p_rdz) else $error("read data not zero outside read answer");
   a_in: assert property (p_in) else $error("input read does not match synchronised pins");
   a_rst: assert property (p_rst) else $error("pins not in reset state");
   a_clk15: assert property (p_clk15) else $error("pin 15 clock not running after reset");
   a_any: assert property (p_any) else $error("summary flag disagrees with flags");
   a_clk14: assert property (p_clk14) else $error("pin 14 not driving in clock mode");
endmodule // gpclk_props
bind gpclk_top gpclk_props #(.NPIN(NPIN), .NIRQ(NIRQ)) u_props (.clk(clk), .rst_b(rst_b),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe_b(pin_oe_b), .event_flags(event_flags), .event_any(event_any));
`default_nettype wire

// ==== verification/gpclk_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpclk_pin_model (
   // Device side
   input  wire logic [15:0] pin_out,
   input  wire logic [15:0] pin_oe_b,
   // Application side
   input  wire logic [15:0] ext,
   output wire logic [15:0] pin_in
);
   // A driven pin reads back its own level; an input sees the outside source
   assign pin_in = (pin_out & ~pin_oe_b) | (ext & pin_oe_b);
endmodule // gpclk_pin_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gpclk_consts.vh"
module tb;
   logic        clk;
   logic        rst_b;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [15:0] pin_in;
   logic [15:0] pin_out;
   logic [15:0] pin_oe_b;
   logic [12:0] event_flags;
   logic        event_any;
   logic [15:0] ext;
   logic [31:0] v;
   logic [15:0] o;
   logic [15:0] d;
   logic [2:0]  e;
   integer      seed;
   integer      err_count;
   integer      check_count;
   integer      t;
   integer      n;
   gpclk_top uut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
      .event_flags(event_flags), .event_any(event_any));
   gpclk_pin_model u_pins (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .ext(ext), .pin_in(pin_in));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wreg(input logic [3:0] a, input logic [31:0] dd);
      @(posedge clk);
      addr <= a;
      wdata <= dd;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Flag after rise, after fall, after clear with the pin low
   function automatic logic [2:0] exp_tab(input integer ty);
      case (ty)
         0: exp_tab = 3'b100;
         1: exp_tab = 3'b011;
         3: exp_tab = 3'b010;
         default: exp_tab = 3'b110;
      endcase
   endfunction
   initial
   begin
      #80000;
      err_count = err_count + 1;
      wrap_up;
   end
   initial
   begin
      seed = 32'h6df0;
      err_count = 0;
      check_count = 0;
      rst_b = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      ext = 16'h0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1 chk(pin_oe_b, 16'h7fff);
      rreg(`GPCLK_OFS_DIR);
      chk(v, 32'hffff);
      rreg(`GPCLK_OFS_CLKCTL);
      chk(v, 32'h2);
      rreg(4'hf);
      chk(v, 32'h0);
      $display("reset test done");
      wreg(`GPCLK_OFS_CLKCTL, 32'h0);
      repeat (4)
      begin
         @(posedge clk) ext <= 16'($random(seed));
         o = 16'($random(seed));
         d = 16'($random(seed));
         wreg(`GPCLK_OFS_OUT, {16'h0, o});
         wreg(`GPCLK_OFS_DIR, {16'h0, d});
         repeat (4) @(posedge clk);
         #1 chk(pin_oe_b, d);
         chk(pin_out & ~d, o & ~d);
         rreg(`GPCLK_OFS_IN);
         chk(v, {16'h0, (o & ~d) | (ext & d)});
      end
      $display("direction test done");
      wreg(`GPCLK_OFS_DIR, 32'hffff);
      wreg(`GPCLK_OFS_IEN, 32'h1fff);
      for (t = 0; t < 5; t = t + 1)
      begin
         e = exp_tab(t);
         @(posedge clk) ext <= 16'h0;
         wreg(`GPCLK_OFS_TYPE_LO, t);
         repeat (6) @(posedge clk);
         wreg(`GPCLK_OFS_STAT, 32'h1fff);
         @(posedge clk) ext <= 16'h1;
         repeat (6) @(posedge clk);
         #1 chk({event_any, event_flags}, {e[2], 12'h0, e[2]});
         @(posedge clk) ext <= 16'h0;
         repeat (6) @(posedge clk);
         #1 chk(event_flags[0], e[1]);
         wreg(`GPCLK_OFS_STAT, 32'h1fff);
         repeat (2) @(posedge clk);
         #1 chk(event_flags[0], e[0]);
      end
      $display("detection test done");
      wreg(`GPCLK_OFS_DIR, 32'hfffe);
      wreg(`GPCLK_OFS_TYPE_LO, `GPCLK_DET_BOTH);
      repeat (6) @(posedge clk);
      wreg(`GPCLK_OFS_STAT, 32'h1fff);
      wreg(`GPCLK_OFS_OUT, 32'h1);
      wreg(`GPCLK_OFS_OUT, 32'h0);
      repeat (6) @(posedge clk);
      #1 chk(event_flags, 13'h0);
      $display("output pin test done");
      wreg(`GPCLK_OFS_DIV14, 32'h2);
      wreg(`GPCLK_OFS_CLKCTL, 32'h3);
      @(posedge pin_out[14]);
      @(negedge clk);
      n = 0;
      while (pin_out[14])
      begin
         n = n + 1;
         @(negedge clk);
      end
      chk(n, 3);
      chk(pin_oe_b[15:14], 2'h0);
      $display("clock test done");
      wrap_up;
   end
endmodule // tb
`default_nettype wire
